// ==== verilog/rcs_pkg.sv ====
// Purpose: Constants and types for the reader command/status register page
// Assumes: 8-bit host register bus, 100 MHz system clock
// Notes:   Offsets are register addresses within page 0
package rcs_pkg;

  localparam logic [5:0] RCS_OFS_PAGE   = 6'h00;
  localparam logic [5:0] RCS_OFS_CMD    = 6'h01;
  localparam logic [5:0] RCS_OFS_QDATA  = 6'h02;
  localparam logic [5:0] RCS_OFS_STATUS = 6'h03;
  localparam logic [2:0] RCS_PAGE_ALIAS_MASK = 3'h7;

  localparam logic [7:0] RCS_PAGE_RESET   = 8'h80;
  localparam logic [7:0] RCS_STATUS_RESET = 8'h05;
  localparam logic [5:0] RCS_CMD_RESET    = 6'h00;
  localparam logic [5:0] RCS_CMD_IDLE     = 6'h00;
  localparam int         RCS_PAGE_EN_BIT  = 7;
  localparam int         RCS_QUEUE_DEPTH  = 64;
  localparam int         RCS_CNT_W        = 7;
  localparam int         RCS_THR_W        = 6;

  localparam logic [2:0] RCS_LS_IDLE      = 3'h0;
  localparam logic [2:0] RCS_LS_TX_SOF    = 3'h1;
  localparam logic [2:0] RCS_LS_TX_DATA   = 3'h2;
  localparam logic [2:0] RCS_LS_TX_EOF    = 3'h3;
  localparam logic [2:0] RCS_LS_RX_STEP   = 3'h4;
  localparam logic [2:0] RCS_LS_RX_GUARD  = 3'h5;
  localparam logic [2:0] RCS_LS_RX_ARMED  = 3'h6;
  localparam logic [2:0] RCS_LS_RX_DATA   = 3'h7;

  // Host bus access as seen by the register page
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rcs_host_req_t;

  // State reported by the surrounding engine
  typedef enum logic [9:0] {
    RCS_ST_IDLE     = 10'h001,
    RCS_ST_TX_SOF   = 10'h002,
    RCS_ST_TX_DATA  = 10'h004,
    RCS_ST_TX_EOF   = 10'h008,
    RCS_ST_RX_ENTRY = 10'h010,
    RCS_ST_RX_EXIT  = 10'h020,
    RCS_ST_RX_GUARD = 10'h040,
    RCS_ST_RX_ARMED = 10'h080,
    RCS_ST_RX_DATA  = 10'h100,
    RCS_ST_SPARE    = 10'h200
  } rcs_link_state_t;

endpackage

// ==== verilog/rcs_queue.sv ====
// Purpose: Byte queue with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Count is one bit wider than the index to show full
`timescale 1ns/1ps
module rcs_queue import rcs_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH) + 1
) (
  input  wire logic             clk_sys_in,  // System clock
  input  wire logic             reset_in,    // Sync reset
  input  wire logic             flush_in,    // Drop all entries
  input  wire logic             in_valid_in, // Fill strobe
  output logic                  in_ready_out,// Room available
  input  wire logic [WIDTH-1:0] in_data_in,  // Fill data
  output logic                  out_valid_out,// Data available
  input  wire logic             out_ready_in,// Drain strobe
  output logic      [WIDTH-1:0] out_data_out,// Head data
  output logic      [CNT_W-1:0] count_out    // Fill level
);
  localparam int IW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [IW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready_out  = (cnt_r != CNT_W'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
  assign count_out     = cnt_r;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_ready_in & out_valid_out;

  always_comb begin
    wp_nxt  = push ? IW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? IW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = CNT_W'(cnt_r + CNT_W'(push) - CNT_W'(pop));
    if (flush_in) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk_sys_in) begin
    if (push && !flush_in) begin
      mem_r[wp_r] <= in_data_in;
    end
  end

endmodule

// ==== verilog/rcs_regs.sv ====
// Purpose: Command and status register page of a card reader
// Assumes: Host bus inputs are synchronous to clk_sys_in
// Notes:   Command engine, timer and interrupt registers live outside
//
// Overview of operation
// - Page mode on: page number supplies register address bits 5..3.
// - Page mode on: low address bits come from pins or address latch.
// - Page mode off: page number ignored, address latch used whole.
// - Page register aliases every eighth address; resets to 80h.
// - Writing the command field starts that command.
// - Reading the command field returns the running command.
// - Command field and reserved bit reset to zero.
// - Top command bit reads 1 while host interface detection runs.
// - Data port writes push the buffer, reads pop it.
// - Buffer carries every stream as parallel bytes in and out.
// - Link state 000 idle, 001 start, 010 payload, 011 frame end.
// - Link state 100 in both receiver transition steps.
// - Link state 101 guard wait, 110 armed, 111 receiving.
// - Status bit 3 set when any enabled interrupt source requests.
// - Main status resets to 05h.
// - Status bit 2 set when any error flag is set.
// - Near-full alert when 64 minus fill count is at most threshold.
// - Near-empty alert when fill count is at most threshold.
// - Fill count rises per data write and falls per data read.
`timescale 1ns/1ps
module rcs_regs import rcs_pkg::*; #(
  parameter int QDEPTH = RCS_QUEUE_DEPTH,
  parameter int CNT_W  = RCS_CNT_W
) (
  input  wire logic            clk_sys_in,       // System clock
  input  wire logic            reset_in,         // Sync reset, high
  input  wire rcs_host_req_t   host_req_in,      // Host access strobe
  input  wire logic            addr_from_pins_in,// Pin-addressed host
  input  wire logic [2:0]      addr_pins_in,     // Address pins A2..A0
  input  wire logic [5:0]      addr_latch_in,    // Internal address latch
  output logic      [7:0]      host_rdata_out,   // Read data
  output logic      [5:0]      reg_addr_out,     // Resolved address
  output logic                 page0_hit_out,    // Address in this page
  input  wire logic            host_if_detect_pending_in, // Detect busy
  output logic                 cmd_start_out,    // Command start pulse
  output logic      [5:0]      cmd_code_out,     // Code to start
  input  wire logic [5:0]      cmd_running_in,   // Code being executed
  input  wire rcs_link_state_t link_fsm_in,      // Engine link state
  input  wire logic [7:0]      irq_request_in,   // Interrupt requests
  input  wire logic [7:0]      irq_enable_mask_in, // Interrupt enables
  input  wire logic [7:0]      error_flag_reg_in,  // Error flags
  input  wire logic [RCS_THR_W-1:0] alert_threshold_in, // Alert level
  input  wire logic            flush_in,         // Empty the buffer
  input  wire logic            eng_push_in,      // Engine byte in
  input  wire logic [7:0]      eng_wdata_in,     // Engine byte data
  output logic                 eng_push_ready_out, // Buffer has room
  input  wire logic            eng_pop_in,       // Engine byte out
  output logic                 eng_pop_valid_out,// Buffer has data
  output logic      [7:0]      eng_rdata_out,    // Engine head byte
  output logic      [CNT_W-1:0] queue_fill_count_out, // Fill level
  output logic      [7:0]      main_status_out   // Status snapshot
);

  logic [7:0]       page_r, page_nxt;
  logic [5:0]       addr;
  logic             rd_page, wr_page, rd_cmd, wr_cmd, rd_q, wr_q, rd_st;
  logic             q_in_ready, q_out_valid, q_push, q_pop;
  logic [7:0]       q_in_data, q_out_data;
  logic [CNT_W-1:0] q_cnt;
  logic [2:0]       link_state;
  logic             near_full, near_empty, irq_sum, err_sum;
  logic [7:0]       status_nxt, status_r;
  logic [7:0]       rdata_nxt, rdata_r;
  logic             page_mode_enable;
  logic [2:0]       page_number;

  assign page_mode_enable = page_r[RCS_PAGE_EN_BIT];
  assign page_number      = page_r[2:0];

  // Address resolution
  always_comb begin
    if (page_mode_enable) begin
      addr[5:3] = page_number;
      addr[2:0] = addr_from_pins_in ? addr_pins_in
                                    : addr_latch_in[2:0];
    end else begin
      addr = addr_latch_in;
    end
  end
  assign reg_addr_out  = addr;
  assign page0_hit_out = (addr[5:3] == 3'h0) || (addr[2:0] == 3'h0);

  // Page register visible at every multiple of eight
  assign rd_page = host_req_in.rd && (addr[2:0] == RCS_OFS_PAGE[2:0]);
  assign wr_page = host_req_in.wr && (addr[2:0] == RCS_OFS_PAGE[2:0]);
  assign rd_cmd  = host_req_in.rd && (addr == RCS_OFS_CMD);
  assign wr_cmd  = host_req_in.wr && (addr == RCS_OFS_CMD);
  assign rd_q    = host_req_in.rd && (addr == RCS_OFS_QDATA);
  assign wr_q    = host_req_in.wr && (addr == RCS_OFS_QDATA);
  assign rd_st   = host_req_in.rd && (addr == RCS_OFS_STATUS);

  always_comb begin
    page_nxt = page_r;
    if (wr_page) begin
      page_nxt = {host_req_in.wdata[7], 4'h0, host_req_in.wdata[2:0]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      page_r <= RCS_PAGE_RESET;
    end else begin
      page_r <= page_nxt;
    end
  end

  // Command start: only the low six bits are taken
  assign cmd_start_out = wr_cmd;
  assign cmd_code_out  = host_req_in.wdata[5:0];

  // Buffer: host has priority over the engine on each side
  assign q_push     = wr_q | eng_push_in;
  assign q_in_data  = wr_q ? host_req_in.wdata : eng_wdata_in;
  assign q_pop      = rd_q | (eng_pop_in & ~rd_q);
  assign eng_push_ready_out = q_in_ready & ~wr_q;
  assign eng_pop_valid_out  = q_out_valid & ~rd_q;
  assign eng_rdata_out      = q_out_data;

  rcs_queue #(
    .WIDTH (8),
    .DEPTH (QDEPTH),
    .CNT_W (CNT_W)
  ) u_queue (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .flush_in      (flush_in),
    .in_valid_in   (q_push),
    .in_ready_out  (q_in_ready),
    .in_data_in    (q_in_data),
    .out_valid_out (q_out_valid),
    .out_ready_in  (q_pop),
    .out_data_out  (q_out_data),
    .count_out     (q_cnt)
  );
  assign queue_fill_count_out = q_cnt;

  // Link state encoding
  always_comb begin
    unique case (link_fsm_in)
      RCS_ST_IDLE:     link_state = RCS_LS_IDLE;
      RCS_ST_TX_SOF:   link_state = RCS_LS_TX_SOF;
      RCS_ST_TX_DATA:  link_state = RCS_LS_TX_DATA;
      RCS_ST_TX_EOF:   link_state = RCS_LS_TX_EOF;
      RCS_ST_RX_ENTRY,
      RCS_ST_RX_EXIT:  link_state = RCS_LS_RX_STEP;
      RCS_ST_RX_GUARD: link_state = RCS_LS_RX_GUARD;
      RCS_ST_RX_ARMED: link_state = RCS_LS_RX_ARMED;
      RCS_ST_RX_DATA:  link_state = RCS_LS_RX_DATA;
      default:         link_state = RCS_LS_IDLE;
    endcase
  end

  // Alerts compare in 8 bits so 64 minus count never wraps
  assign near_full  = (8'(QDEPTH) - 8'(q_cnt))
                      <= 8'(alert_threshold_in);
  assign near_empty = 8'(q_cnt) <= 8'(alert_threshold_in);
  assign irq_sum    = |(irq_request_in & irq_enable_mask_in);
  assign err_sum    = |error_flag_reg_in;

  // Status is never written by the host
  always_comb begin
    status_nxt = {1'b0, link_state, irq_sum, err_sum,
                  near_full, near_empty};
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      status_r <= RCS_STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end
  assign main_status_out = status_r;

  // Read data registered one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_page) begin
      rdata_nxt = page_r;
    end else if (rd_cmd) begin
      rdata_nxt = {host_if_detect_pending_in, 1'b0,
                   cmd_running_in};
    end else if (rd_q) begin
      rdata_nxt = q_out_data;
    end else if (rd_st) begin
      rdata_nxt = status_r;
    end else if (host_req_in.rd) begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign host_rdata_out = rdata_r;

  a_page_route: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    page_mode_enable |-> reg_addr_out[5:3] == page_r[2:0])
    else $error("page number not routed");
  a_latch_route: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !page_mode_enable |-> reg_addr_out == addr_latch_in)
    else $error("latch address not used");
  a_page_write: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    wr_page |=> page_r == {$past(host_req_in.wdata[7]), 4'h0,
                           $past(host_req_in.wdata[2:0])})
    else $error("page write lost");
  a_cmd_read: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    rd_cmd |=> host_rdata_out == {$past(host_if_detect_pending_in),
                                  1'b0, $past(cmd_running_in)})
    else $error("command readback wrong");

  // Host data port accesses made alone in that cycle
  sequence s_host_push;
    wr_q && q_in_ready && !rd_q && !eng_pop_in && !flush_in;
  endsequence
  sequence s_host_pop;
    rd_q && q_out_valid && !wr_q && !eng_push_in && !flush_in;
  endsequence
  sequence s_full_push;
    wr_q && !q_in_ready && !rd_q && !eng_pop_in && !flush_in;
  endsequence
  // Reset seen, then the first edge with reset released
  sequence s_reset_exit;
    reset_in ##1 !reset_in;
  endsequence

  a_fill_count: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    s_host_push |=> q_cnt == $past(q_cnt) + 1'b1)
    else $error("fill count not incremented");
  a_fill_drop: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    s_host_pop |=> q_cnt == $past(q_cnt) - 1'b1)
    else $error("fill count not decremented");
  a_full_hold: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    s_full_push |=> q_cnt == $past(q_cnt))
    else $error("write to full buffer counted");
  a_flush_empty: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    flush_in |=> q_cnt == '0)
    else $error("flush left bytes behind");
  a_queue_read: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    rd_q |=> host_rdata_out == $past(q_out_data))
    else $error("data port read wrong");
  a_rdata_hold: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !host_req_in.rd |=> host_rdata_out == $past(host_rdata_out))
    else $error("read data changed without a read");
  a_status_irq: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    |(irq_request_in & irq_enable_mask_in) |=> status_r[3])
    else $error("irq summary missing");
  a_irq_clear: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !(|(irq_request_in & irq_enable_mask_in)) |=> !status_r[3])
    else $error("irq summary set without source");
  a_status_err: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (error_flag_reg_in == 8'h00) |=> !status_r[2])
    else $error("error summary wrong");
  a_err_set: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (error_flag_reg_in != 8'h00) |=> status_r[2])
    else $error("error summary missing");
  a_near_empty: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (q_cnt > CNT_W'(alert_threshold_in)) |=> !status_r[0])
    else $error("near empty alert wrong");
  a_full_alert: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (QDEPTH - int'(q_cnt) <= int'(alert_threshold_in)) |=> status_r[1])
    else $error("near full alert missing");
  a_rx_step: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (link_fsm_in inside {RCS_ST_RX_ENTRY, RCS_ST_RX_EXIT})
      |=> status_r[6:4] == RCS_LS_RX_STEP)
    else $error("rx step code wrong");
  a_tx_payload: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (link_fsm_in == RCS_ST_TX_DATA) |=> status_r[6:4] == RCS_LS_TX_DATA)
    else $error("payload code wrong");
  a_rx_armed: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (link_fsm_in == RCS_ST_RX_ARMED) |=> status_r[6:4] == RCS_LS_RX_ARMED)
    else $error("armed code wrong");
  a_reset_values: assert property (@(posedge clk_sys_in)
    s_reset_exit |-> status_r == RCS_STATUS_RESET &&
      page_r == RCS_PAGE_RESET)
    else $error("reset values wrong");

endmodule

// ==== verification/rcs_host_model.sv ====
// Purpose: Host microprocessor model driving the register page bus
// Assumes: Requests launched just after a rising edge, one cycle long
// Notes:   Pin and latch addressing picked at random per access
`timescale 1ns/1ps
module rcs_host_model import rcs_pkg::*; (
  input  wire logic    clk_sys_in,         // System clock
  input  wire logic [7:0] host_rdata_in,   // Read data from page
  output rcs_host_req_t host_req_out,      // Request strobe
  output logic         addr_from_pins_out, // Pin-addressed host
  output logic [2:0]   addr_pins_out,      // Address pins
  output logic [5:0]   addr_latch_out      // Address latch
);
  initial begin
    host_req_out       = '0;
    addr_from_pins_out = 1'b1;
    addr_pins_out      = 3'h0;
    addr_latch_out     = 6'h00;
  end

  // Pins and latch carry the same low bits, so either mode addresses alike
  task automatic xfer(input logic rd, input logic wr, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_in);
    host_req_out       <= '{rd: rd, wr: wr, addr: a, wdata: d};
    addr_pins_out      <= a[2:0];
    addr_latch_out     <= a;
    addr_from_pins_out <= 1'($urandom_range(0, 1));
    @(posedge clk_sys_in);
    host_req_out <= '0;
    #1 q = host_rdata_in;
  endtask

  task automatic set_addr(input logic fp, input logic [2:0] p,
                          input logic [5:0] l);
    @(posedge clk_sys_in);
    addr_from_pins_out <= fp;
    addr_pins_out      <= p;
    addr_latch_out     <= l;
    @(posedge clk_sys_in);
    #1;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the command/status register page
// Assumes: Host model on the bus, engine side driven here
// Notes:   Status reads wait two edges for the registered snapshot
`timescale 1ns/1ps
module tb_top import rcs_pkg::*;;
  logic clk_sys_in;
  logic reset_in;
  rcs_host_req_t req;
  logic from_pins, hit, cstart, detp, flush, epush, eready, epop, evalid;
  logic [2:0] pins;
  logic [5:0] latch, raddr, ccode, crun, thr;
  logic [7:0] rdata, q, v, ewd, erd, irq, msk, err, status;
  logic [6:0] cnt;
  rcs_link_state_t ls;
  int err_count, check_count, n, exp_cnt;
  logic [7:0] model_q[$];

  rcs_host_model host (.clk_sys_in(clk_sys_in), .host_rdata_in(rdata),
    .host_req_out(req), .addr_from_pins_out(from_pins),
    .addr_pins_out(pins), .addr_latch_out(latch));

  rcs_regs DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .host_req_in(req), .addr_from_pins_in(from_pins),
    .addr_pins_in(pins), .addr_latch_in(latch), .host_rdata_out(rdata),
    .reg_addr_out(raddr), .page0_hit_out(hit),
    .host_if_detect_pending_in(detp), .cmd_start_out(cstart),
    .cmd_code_out(ccode), .cmd_running_in(crun), .link_fsm_in(ls),
    .irq_request_in(irq), .irq_enable_mask_in(msk),
    .error_flag_reg_in(err), .alert_threshold_in(thr), .flush_in(flush),
    .eng_push_in(epush), .eng_wdata_in(ewd), .eng_push_ready_out(eready),
    .eng_pop_in(epop), .eng_pop_valid_out(evalid), .eng_rdata_out(erd),
    .queue_fill_count_out(cnt), .main_status_out(status));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic complete_run();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e,
                       input string m);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic logic [7:0] exp_status(int c);
    logic [2:0] s;
    case (ls)
      RCS_ST_TX_SOF:   s = RCS_LS_TX_SOF;
      RCS_ST_TX_DATA:  s = RCS_LS_TX_DATA;
      RCS_ST_TX_EOF:   s = RCS_LS_TX_EOF;
      RCS_ST_RX_ENTRY: s = RCS_LS_RX_STEP;
      RCS_ST_RX_EXIT:  s = RCS_LS_RX_STEP;
      RCS_ST_RX_GUARD: s = RCS_LS_RX_GUARD;
      RCS_ST_RX_ARMED: s = RCS_LS_RX_ARMED;
      RCS_ST_RX_DATA:  s = RCS_LS_RX_DATA;
      default:         s = RCS_LS_IDLE;
    endcase
    return {1'b0, s, |(irq & msk), |err, (64 - c) <= int'(thr),
            c <= int'(thr)};
  endfunction

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    host.xfer(1'b1, 1'b0, a, 8'h00, d);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] t;
    host.xfer(1'b0, 1'b1, a, d, t);
  endtask

  task automatic chk_status(input string m);
    logic [7:0] t;
    repeat (2) @(posedge clk_sys_in);
    rd(RCS_OFS_STATUS, t);
    check(t, exp_status(exp_cnt), m);
    check({1'b0, cnt}, 8'(exp_cnt), "fill count");
  endtask

  // Start strobe must accompany every command write, with its code
  always @(posedge clk_sys_in) begin
    if (!reset_in && req.wr && raddr == RCS_OFS_CMD) begin
      check({7'h0, cstart}, 8'h01, "cmd start");
      check({2'h0, ccode}, {2'h0, req.wdata[5:0]}, "cmd code");
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    reset_in = 1'b1; detp = 1'b1; crun = 6'h00; ls = RCS_ST_IDLE;
    irq = 8'h00; msk = 8'h00; err = 8'h00; thr = 6'h04; flush = 1'b0;
    epush = 1'b0; ewd = 8'h00; epop = 1'b0; exp_cnt = 0;
    void'($urandom(32'hb72f));
    repeat (15) @(posedge clk_sys_in);
    #1 check(status, 8'h05, "status reset");
    @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(RCS_OFS_PAGE, q);
    check(q, RCS_PAGE_RESET, "page reset");
    rd(RCS_OFS_CMD, q);
    check(q, 8'h80, "cmd reset");
    detp <= 1'b0;
    for (n = 0; n < 4; n++) begin
      wr(RCS_OFS_CMD, {2'b11, 6'($urandom)});
      crun <= 6'($urandom);
      rd(RCS_OFS_CMD, q);
      check(q, {2'b00, crun}, "cmd readback");
    end
    wr(RCS_OFS_STATUS, 8'hff);
    chk_status("status write");
    for (n = 0; n < 9; n++) begin
      v = 8'($urandom);
      ls <= rcs_link_state_t'(10'h1 << n);
      irq <= v;
      msk <= (n < 3) ? ~v : 8'($urandom);
      err <= (n < 3) ? 8'h00 : 8'($urandom);
      chk_status("link irq err");
    end
    // Fill past full: the last write must be refused
    for (n = 0; n < 65; n++) begin
      v = 8'($urandom);
      wr(RCS_OFS_QDATA, v);
      if (n < 64) begin
        model_q.push_back(v);
        exp_cnt++;
      end
      chk_status("fill");
    end
    thr <= 6'($urandom);
    for (n = 0; n < 32; n++) begin
      rd(RCS_OFS_QDATA, q);
      check(q, model_q.pop_front(), "drain data");
      exp_cnt--;
      chk_status("drain");
    end
    @(posedge clk_sys_in);
    flush <= 1'b1;
    @(posedge clk_sys_in);
    flush <= 1'b0;
    exp_cnt = 0;
    chk_status("flush");
    v = 8'($urandom);
    @(posedge clk_sys_in);
    #1 check({7'h0, eready}, 8'h01, "engine ready");
    epush <= 1'b1;
    ewd <= v;
    @(posedge clk_sys_in);
    epush <= 1'b0;
    rd(RCS_OFS_QDATA, q);
    check(q, v, "engine to host");
    wr(RCS_OFS_QDATA, ~v);
    #1 check({evalid, 7'h0} | 8'(erd == ~v), 8'h81, "host to engine");
    epop <= 1'b1;
    @(posedge clk_sys_in);
    epop <= 1'b0;
    chk_status("engine pop");
    wr(RCS_OFS_PAGE, 8'hfb);
    rd(RCS_OFS_PAGE, q);
    check(q, 8'h83, "page alias");
    v = 8'($urandom);
    host.set_addr(1'b1, v[2:0], ~v[5:0]);
    check({2'h0, raddr}, {2'h0, 3'h3, v[2:0]}, "pin addr");
    check({7'h0, hit}, {7'h0, v[2:0] == 3'h0}, "page hit");
    host.set_addr(1'b0, ~v[2:0], v[5:0]);
    check({2'h0, raddr}, {2'h0, 3'h3, v[2:0]}, "latch addr");
    wr(RCS_OFS_PAGE, 8'h00);
    host.set_addr(v[7], v[2:0], ~v[5:0]);
    check({2'h0, raddr}, {2'h0, ~v[5:0]}, "flat addr");
    rd(6'h38, q);
    check(q, 8'h00, "page at 38h");
    wr(6'h08, RCS_PAGE_RESET);
    rd(6'h00, q);
    check(q, RCS_PAGE_RESET, "page at 08h");
    complete_run();
  end
endmodule
